// >>> logic/sad_decoder.sv
`timescale 1ns/1ps
module sad_decoder
  import sad_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // master request side
  input wire sad_req_s i_req,
  output logic o_req_ready,
  // master answer side
  output logic o_resp_valid,
  output logic o_resp_fault,
  output logic [31:0] o_resp_rdata,
  output logic o_fault_event,
  // target side
  output sad_tgt_req_s o_tgt,
  input wire logic i_tgt_ready,
  input wire logic [31:0] i_tgt_rdata
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [31:0] a;               // shorthand for request address
  sad_target_e dec_target;      // target chosen for the address
  logic dec_alias;              // address hits a bit alias
  logic [31:0] alias_word;      // word address behind an alias
  logic [4:0] alias_bit;        // bit number behind an alias
  logic dec_exec_never;         // fetch from execute-never space
  logic dec_bad_size;           // unsupported transfer size
  logic dec_misalign;           // unaligned halfword or word
  logic [3:0] dec_be;           // lane enables
  logic [31:0] dec_wdata;       // write data moved onto its lanes

  assign a = i_req.addr;

  // address to target; 32-bit compare covers all of 4 GB
  always_comb begin
    dec_target = SAD_TGT_NONE;
    dec_alias = 1'b0;
    alias_word = 32'h0;
    alias_bit = 5'h0;
    if (a <= SAD_FLASH_END) begin
      dec_target = SAD_TGT_FLASH;
    end else if (a >= SAD_SRAM_BASE && a <= SAD_SRAM_END) begin
      dec_target = SAD_TGT_SRAM;
    end else if (a >= SAD_SRAM_ALIAS_BASE && a <= SAD_SRAM_ALIAS_END) begin
      // each alias word maps one bit of sram
      dec_alias = 1'b1;
      alias_word = SAD_SRAM_BASE + {14'h0, a[22:7], 2'h0};
      alias_bit = a[6:2];
      dec_target = SAD_TGT_SRAM;
    end else if (a >= SAD_PERIPH_ALIAS_BASE && a <= SAD_PERIPH_ALIAS_END) begin
      // alias of peripheral megabyte
      dec_alias = 1'b1;
      alias_word = SAD_PERIPH_BASE + {12'h0, a[24:7], 2'h0};
      alias_bit = a[6:2];
      dec_target = SAD_TGT_NONE;
    end else if (a >= SAD_WDOG_BASE && a < SAD_WDOG_BASE + SAD_SLOT_SIZE) begin
      dec_target = SAD_TGT_WDOG;
    end else if (a >= SAD_PORT0_BASE &&
                 a < SAD_PORT0_BASE + SAD_SLOT_SIZE * SAD_PORT_COUNT) begin
      dec_target = SAD_TGT_PORT;
    end else if (a >= SAD_FLASHCTL_BASE && a < SAD_FLASHCTL_BASE + SAD_SLOT_SIZE) begin
      dec_target = SAD_TGT_FLASHCTL;
    end else if (a >= SAD_SYSCTL_BASE && a < SAD_SYSCTL_BASE + SAD_SLOT_SIZE) begin
      dec_target = SAD_TGT_SYSCTL;
    end else if (a >= SAD_TRACE_MACRO_BASE &&
                 a < SAD_TRACE_MACRO_BASE + SAD_SLOT_SIZE * SAD_DEBUG_SLOT_COUNT) begin
      // three consecutive debug slots
      case (a[13:12])
        2'h0: dec_target = SAD_TGT_TRACE_MACRO;
        2'h1: dec_target = SAD_TGT_WATCHPOINT;
        default: dec_target = SAD_TGT_PATCH_BKPT;
      endcase
    end else if (a >= SAD_CORE_PERIPH_BASE && a < SAD_CORE_PERIPH_BASE + SAD_SLOT_SIZE) begin
      dec_target = SAD_TGT_CORE_PERIPH;
    end else if (a >= SAD_TRACE_PORT_BASE && a < SAD_TRACE_PORT_BASE + SAD_SLOT_SIZE) begin
      dec_target = SAD_TGT_TRACE_PORT;
    end
    // peripheral alias resolves to the peripheral slot behind it
    if (dec_alias && a >= SAD_PERIPH_ALIAS_BASE) begin
      if (alias_word < SAD_WDOG_BASE + SAD_SLOT_SIZE) begin
        dec_target = SAD_TGT_WDOG;
      end else if (alias_word >= SAD_PORT0_BASE &&
                   alias_word < SAD_PORT0_BASE + SAD_SLOT_SIZE * SAD_PORT_COUNT) begin
        dec_target = SAD_TGT_PORT;
      end else if (alias_word >= SAD_FLASHCTL_BASE && alias_word < SAD_SYSCTL_BASE) begin
        dec_target = SAD_TGT_FLASHCTL;
      end else if (alias_word >= SAD_SYSCTL_BASE && alias_word < SAD_SYSCTL_BASE + SAD_SLOT_SIZE) begin
        dec_target = SAD_TGT_SYSCTL;
      end else begin
        dec_target = SAD_TGT_NONE;
      end
    end
  end

  // fetch from peripheral space faults
  assign dec_exec_never = i_req.fetch && a >= SAD_PERIPH_BASE && a <= SAD_PERIPH_EXEC_NEVER_END;
  // only three sizes are legal
  assign dec_bad_size = (i_req.size == SAD_SIZE_BAD);
  assign dec_misalign = (i_req.size == SAD_SIZE_HALF && a[0]) ||
                        (i_req.size == SAD_SIZE_WORD && a[1:0] != 2'h0);

  // little-endian lanes: lowest byte address on lane 0
  always_comb begin
    case (i_req.size)
      SAD_SIZE_BYTE: dec_be = SAD_BE_BYTE << a[1:0];
      SAD_SIZE_HALF: dec_be = SAD_BE_HALF << {a[1], 1'b0};
      SAD_SIZE_WORD: dec_be = SAD_BE_WORD;
      default: dec_be = SAD_BE_NONE;
    endcase
    dec_wdata = i_req.wdata << {a[1:0], 3'h0};
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  sad_state_e state;            // alias sequencer state
  logic [31:0] hold_word;       // alias word address
  logic [4:0] hold_bit;         // alias bit number
  logic hold_val;               // bit value to write
  logic hold_write;             // alias access is a write
  sad_target_e hold_target;     // alias target
  logic [31:0] hold_rdata;      // word read in the first alias step
  logic dec_fault;              // request must fault
  logic take;                   // request accepted this cycle

  assign dec_fault = (dec_target == SAD_TGT_NONE) || dec_exec_never || dec_bad_size || dec_misalign;
  // ready only while idle; alias sequence locks the bus
  assign o_req_ready = (state == SAD_ST_IDLE) && (dec_fault || dec_alias || i_tgt_ready);
  assign take = i_req.valid && o_req_ready;

  // alias state walks read then, for a write, write without releasing target
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state <= SAD_ST_IDLE;
    end else begin
      case (state)
        SAD_ST_IDLE: if (take && dec_alias && !dec_fault) state <= SAD_ST_READ;
        SAD_ST_READ: if (i_tgt_ready) state <= hold_write ? SAD_ST_WRITE : SAD_ST_IDLE;
        SAD_ST_WRITE: if (i_tgt_ready) state <= SAD_ST_IDLE;
        default: state <= SAD_ST_IDLE;
      endcase
    end
  end

  // capture alias details
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      hold_word <= 32'h0;
      hold_bit <= 5'h0;
      hold_val <= 1'b0;
      hold_write <= 1'b0;
      hold_target <= SAD_TGT_NONE;
    end else if (take && dec_alias) begin
      hold_word <= alias_word;
      hold_bit <= alias_bit;
      hold_val <= i_req.wdata[0];
      hold_write <= i_req.write;
      hold_target <= dec_target;
    end
  end

  // keep the read word so write data stands still while the target waits
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      hold_rdata <= 32'h0;
    end else if (state == SAD_ST_READ && i_tgt_ready) begin
      hold_rdata <= i_tgt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // target drive
  // ----------------------------------------------------------------
  logic [31:0] rmw_data;        // read word with bit replaced
  logic [31:0] t_addr;          // address to target

  always_comb begin
    rmw_data = hold_rdata;
    rmw_data[hold_bit] = hold_val;
  end

  // no target sees a faulting access
  always_comb begin
    o_tgt = '0;
    t_addr = a;
    if (state == SAD_ST_IDLE) begin
      if (i_req.valid && !dec_fault && !dec_alias) begin
        o_tgt.valid = 1'b1;
        o_tgt.write = i_req.write;
        o_tgt.target = dec_target;
        o_tgt.byte_en = dec_be;
        o_tgt.wdata = dec_wdata;
      end
    end else begin
      t_addr = hold_word;
      o_tgt.valid = 1'b1;
      o_tgt.target = hold_target;
      o_tgt.byte_en = SAD_BE_WORD;
      o_tgt.write = (state == SAD_ST_WRITE);
      o_tgt.wdata = rmw_data;
    end
    o_tgt.addr = t_addr;
    // slot index and offset split apart
    o_tgt.offset = t_addr[SAD_SLOT_BITS-1:0];
    o_tgt.port_index = t_addr[13:12];
  end

  // ----------------------------------------------------------------
  // answer
  // ----------------------------------------------------------------
  logic [31:0] read_word;       // word for the answer

  // bit alias reads return the bit in lane 0
  assign read_word = (state == SAD_ST_READ) ? {31'h0, i_tgt_rdata[hold_bit]} : i_tgt_rdata;

  // registered answer; fault answered in the next cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_resp_valid <= 1'b0;
      o_resp_fault <= 1'b0;
      o_resp_rdata <= 32'h0;
      o_fault_event <= 1'b0;
    end else begin
      o_resp_valid <= 1'b0;
      o_resp_fault <= 1'b0;
      o_fault_event <= 1'b0;
      if (take && dec_fault) begin
        o_resp_valid <= 1'b1;
        o_resp_fault <= 1'b1;
        o_fault_event <= 1'b1;
        o_resp_rdata <= 32'h0;
      end else if (take && !dec_alias) begin
        o_resp_valid <= 1'b1;
        o_resp_rdata <= i_tgt_rdata;
      end else if (state == SAD_ST_READ && i_tgt_ready && !hold_write) begin
        o_resp_valid <= 1'b1;
        o_resp_rdata <= read_word;
      end else if (state == SAD_ST_WRITE && i_tgt_ready) begin
        o_resp_valid <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_fault_reply;
    @(posedge i_clock) disable iff (i_rst)
    take && dec_fault |=> o_resp_valid && o_resp_fault && o_fault_event;
  endproperty
  a_fault_reply: assert property (p_fault_reply) else $error("reserved access not faulted");

  property p_fault_quiet;
    @(posedge i_clock) disable iff (i_rst)
    state == SAD_ST_IDLE && i_req.valid && dec_fault |-> !o_tgt.valid;
  endproperty
  a_fault_quiet: assert property (p_fault_quiet) else $error("faulting access reached target");

  property p_flash;
    @(posedge i_clock) disable iff (i_rst)
    i_req.valid && a <= 32'h0000_FFFF |-> dec_target == SAD_TGT_FLASH;
  endproperty
  a_flash: assert property (p_flash) else $error("flash decode wrong");

  property p_gap;
    @(posedge i_clock) disable iff (i_rst)
    i_req.valid && a >= 32'h0001_0000 && a <= 32'h1FFF_FFFF |-> dec_fault;
  endproperty
  a_gap: assert property (p_gap) else $error("reserved code space accepted");

  property p_sram;
    @(posedge i_clock) disable iff (i_rst)
    i_req.valid && a >= 32'h2000_0000 && a <= 32'h2000_1FFF |-> dec_target == SAD_TGT_SRAM && !dec_alias;
  endproperty
  a_sram: assert property (p_sram) else $error("sram decode wrong");

  property p_alias_seq;
    @(posedge i_clock) disable iff (i_rst)
    state == SAD_ST_READ && i_tgt_ready && hold_write |=>
      state == SAD_ST_WRITE && o_tgt.write && o_tgt.addr == $past(o_tgt.addr);
  endproperty
  a_alias_seq: assert property (p_alias_seq) else $error("alias write not atomic");

  property p_rmw_stable;
    @(posedge i_clock) disable iff (i_rst)
    state == SAD_ST_WRITE && !i_tgt_ready |=> $stable(o_tgt.wdata);
  endproperty
  a_rmw_stable: assert property (p_rmw_stable) else $error("alias write data moved");

  property p_lock;
    @(posedge i_clock) disable iff (i_rst)
    state != SAD_ST_IDLE |-> !o_req_ready;
  endproperty
  a_lock: assert property (p_lock) else $error("bus released mid alias");

  property p_exec_never;
    @(posedge i_clock) disable iff (i_rst)
    i_req.valid && i_req.fetch && a[31:29] == 3'h2 |-> dec_fault;
  endproperty
  a_exec_never: assert property (p_exec_never) else $error("fetch from peripheral allowed");

  property p_lanes;
    @(posedge i_clock) disable iff (i_rst)
    i_req.valid && i_req.size == SAD_SIZE_BYTE |-> dec_be == (4'h1 << a[1:0]);
  endproperty
  a_lanes: assert property (p_lanes) else $error("byte lane wrong");

endmodule

// >>> shared/sad_pkg.sv
package sad_pkg;

  // ----------------------------------------------------------------
  // address map constants
  // ----------------------------------------------------------------
  localparam logic [31:0] SAD_FLASH_BASE = 32'h0000_0000;
  localparam logic [31:0] SAD_FLASH_END = 32'h0000_FFFF;
  localparam logic [31:0] SAD_SRAM_BASE = 32'h2000_0000;
  localparam logic [31:0] SAD_SRAM_END = 32'h2000_1FFF;
  localparam logic [31:0] SAD_SRAM_ALIAS_BASE = 32'h2200_0000;
  localparam logic [31:0] SAD_SRAM_ALIAS_END = 32'h2203_FFFF;
  localparam logic [31:0] SAD_PERIPH_BASE = 32'h4000_0000;
  localparam logic [31:0] SAD_PERIPH_END = 32'h400F_FFFF;
  localparam logic [31:0] SAD_PERIPH_EXEC_NEVER_END = 32'h5FFF_FFFF;
  localparam logic [31:0] SAD_PERIPH_ALIAS_BASE = 32'h4200_0000;
  localparam logic [31:0] SAD_PERIPH_ALIAS_END = 32'h43FF_FFFF;
  localparam logic [31:0] SAD_WDOG_BASE = 32'h4000_0000;
  localparam logic [31:0] SAD_PORT0_BASE = 32'h4000_4000;
  localparam logic [31:0] SAD_FLASHCTL_BASE = 32'h400F_D000;
  localparam logic [31:0] SAD_SYSCTL_BASE = 32'h400F_E000;
  localparam logic [31:0] SAD_TRACE_MACRO_BASE = 32'hE000_0000;
  localparam logic [31:0] SAD_CORE_PERIPH_BASE = 32'hE000_E000;
  localparam logic [31:0] SAD_TRACE_PORT_BASE = 32'hE004_0000;

  // ----------------------------------------------------------------
  // slot geometry
  // ----------------------------------------------------------------
  localparam int SAD_SLOT_BITS = 12;   // 4 KB slot
  localparam int SAD_PORT_COUNT = 4;
  localparam int SAD_DEBUG_SLOT_COUNT = 3;
  localparam logic [31:0] SAD_SLOT_SIZE = 32'h0000_1000;

  // ----------------------------------------------------------------
  // transfer sizes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SAD_SIZE_BYTE = 2'h0,
    SAD_SIZE_HALF = 2'h1,
    SAD_SIZE_WORD = 2'h2,
    SAD_SIZE_BAD = 2'h3
  } sad_size_e;

  // ----------------------------------------------------------------
  // targets
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SAD_TGT_NONE = 4'h0,
    SAD_TGT_FLASH = 4'h1,
    SAD_TGT_SRAM = 4'h2,
    SAD_TGT_WDOG = 4'h3,
    SAD_TGT_PORT = 4'h4,
    SAD_TGT_FLASHCTL = 4'h5,
    SAD_TGT_SYSCTL = 4'h6,
    SAD_TGT_TRACE_MACRO = 4'h7,
    SAD_TGT_WATCHPOINT = 4'h8,
    SAD_TGT_PATCH_BKPT = 4'h9,
    SAD_TGT_CORE_PERIPH = 4'hA,
    SAD_TGT_TRACE_PORT = 4'hB
  } sad_target_e;

  // alias read-modify-write sequencer; gray along idle->read->write
  typedef enum logic [1:0] {
    SAD_ST_IDLE = 2'h0,
    SAD_ST_READ = 2'h1,
    SAD_ST_WRITE = 2'h3
  } sad_state_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    sad_size_e size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sad_req_s;

  typedef struct packed {
    logic valid;
    logic write;
    sad_target_e target;
    logic [1:0] port_index;
    logic [11:0] offset;
    logic [31:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } sad_tgt_req_s;

  localparam logic [3:0] SAD_BE_NONE = 4'h0;
  localparam logic [3:0] SAD_BE_BYTE = 4'h1;
  localparam logic [3:0] SAD_BE_HALF = 4'h3;
  localparam logic [3:0] SAD_BE_WORD = 4'hF;

endpackage

// >>> testbench/sad_target_model.sv
`timescale 1ns/1ps
module sad_target_model
  import sad_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // request from the decoder and wait-state setting
  input wire sad_tgt_req_s i_tgt,
  input wire logic [3:0] i_wait,
  // answer to the decoder, access count to the testbench
  output logic o_ready,
  output logic [31:0] o_rdata,
  output int o_acc_cnt
);
  logic [31:0] mem [16]; // tiny store, every target folds onto addr[5:2]
  logic [31:0] last; // last data handed out
  logic [3:0] cnt; // wait states spent on the current access

  // ----------------------------------------------------------------
  // wait states
  // ----------------------------------------------------------------
  // counter restarts on every completed access so alias read and write each pay the full wait
  always_ff @(posedge i_clock) begin
    if (i_rst || !i_tgt.valid || o_ready) begin
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end

  assign o_ready = i_tgt.valid && (cnt == i_wait);
  // stale data is inverted so a decoder sampling too early cannot pass by luck
  assign o_rdata = o_ready ? mem[i_tgt.addr[5:2]] : ~last;

  // ----------------------------------------------------------------
  // storage with byte enables
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_acc_cnt <= 0;
      last <= 32'h0;
      for (int i = 0; i < 16; i++) begin
        mem[i] <= 32'h0;
      end
    end else if (o_ready) begin
      o_acc_cnt <= o_acc_cnt + 1;
      last <= o_rdata;
      // write lanes only where enabled
      for (int i = 0; i < 4; i++) begin
        if (i_tgt.write && i_tgt.byte_en[i]) begin
          mem[i_tgt.addr[5:2]][8*i+:8] <= i_tgt.wdata[8*i+:8];
        end
      end
    end
  end
endmodule

// >>> testbench/tb_system_address_decoder.sv
`timescale 1ns/1ps
module tb_system_address_decoder
  import sad_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic i_clock; // 100 ns clock
  logic i_rst; // sync reset
  sad_req_s i_req; // master request
  logic o_req_ready, o_resp_valid, o_resp_fault, o_fault_event;
  logic [31:0] o_resp_rdata;
  sad_tgt_req_s o_tgt; // decoder to target
  logic tgt_ready; // model answer
  logic [31:0] tgt_rdata;
  logic [3:0] wcyc; // model wait states
  int acc; // model access count
  int error_cnt = 0;
  int checks_done = 0;
  sad_tgt_req_s tq; // target request seen at the take edge
  logic flt, ev; // fault and event of the last answer
  logic [31:0] rd; // read data of the last answer
  int a0; // access count snapshot

  sad_decoder i_sad_decoder (.i_clock(i_clock), .i_rst(i_rst), .i_req(i_req), .o_req_ready(o_req_ready),
    .o_resp_valid(o_resp_valid), .o_resp_fault(o_resp_fault), .o_resp_rdata(o_resp_rdata),
    .o_fault_event(o_fault_event), .o_tgt(o_tgt), .i_tgt_ready(tgt_ready), .i_tgt_rdata(tgt_rdata));
  sad_target_model i_sad_target_model (.i_clock(i_clock), .i_rst(i_rst), .i_tgt(o_tgt), .i_wait(wcyc),
    .o_ready(tgt_ready), .o_rdata(tgt_rdata), .o_acc_cnt(acc));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one transfer: hold request until taken, then wait for the answer, which stands at the take edge for plain accesses and comes later for alias ones
  task automatic xfer(input logic w, input logic f, input sad_size_e sz, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_req = '{valid: 1'b1, write: w, fetch: f, size: sz, addr: a, wdata: d};
    do begin
      @(posedge i_clock);
      n++;
    end while (!o_req_ready && n < 40);
    tq = o_tgt;
    #1;
    i_req.valid = 1'b0;
    // answer may already stand right after the take edge
    while (!o_resp_valid && n < 40) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    if (n >= 40) chk("handshake", 32'h0, 32'h1);
    flt = o_resp_fault;
    ev = o_fault_event;
    rd = o_resp_rdata;
    // one idle edge so valid is never lowered and raised in one time step
    @(posedge i_clock);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // slot boundaries; SAD_TGT_NONE marks reserved space
  logic [31:0] ma [24] = '{32'h0000_0000, 32'h0000_FFFC, 32'h0001_0000, 32'h1FFF_FFFC, 32'h2000_0000,
    32'h2000_1FFC, 32'h2000_2000, 32'h2204_0000, 32'h4000_0FFC, 32'h4000_1000, 32'h4000_3FFC, 32'h400F_D004,
    32'h400F_E008, 32'h400F_F000, 32'h4400_0000, 32'hE000_0000, 32'hE000_1004, 32'hE000_2FFC, 32'hE000_3000,
    32'hE000_E00C, 32'hE000_F000, 32'hE004_0FFC, 32'hE004_1000, 32'hFFFF_FFFC};
  sad_target_e mt [24] = '{SAD_TGT_FLASH, SAD_TGT_FLASH, SAD_TGT_NONE, SAD_TGT_NONE, SAD_TGT_SRAM,
    SAD_TGT_SRAM, SAD_TGT_NONE, SAD_TGT_NONE, SAD_TGT_WDOG, SAD_TGT_NONE, SAD_TGT_NONE, SAD_TGT_FLASHCTL,
    SAD_TGT_SYSCTL, SAD_TGT_NONE, SAD_TGT_NONE, SAD_TGT_TRACE_MACRO, SAD_TGT_WATCHPOINT, SAD_TGT_PATCH_BKPT,
    SAD_TGT_NONE, SAD_TGT_CORE_PERIPH, SAD_TGT_NONE, SAD_TGT_TRACE_PORT, SAD_TGT_NONE, SAD_TGT_NONE};

  // whole map back to back, faults must not touch a target
  task automatic t_map();
    for (int i = 0; i < 24; i++) begin
      a0 = acc;
      xfer(1'b0, 1'b0, SAD_SIZE_WORD, ma[i], 32'h0);
      chk("fault", {31'h0, flt}, {31'h0, mt[i] == SAD_TGT_NONE});
      chk("event", {31'h0, ev}, {31'h0, mt[i] == SAD_TGT_NONE});
      if (mt[i] != SAD_TGT_NONE) begin
        chk("target", {28'h0, tq.target}, {28'h0, mt[i]});
        chk("offset", {20'h0, tq.offset}, {20'h0, ma[i][11:0]});
      end else begin
        chk("no access", acc, a0);
      end
    end
    // four port slots in order
    for (int p = 0; p < 4; p++) begin
      xfer(1'b0, 1'b0, SAD_SIZE_WORD, 32'h4000_4010 + 32'(p) * SAD_SLOT_SIZE, 32'h0);
      chk("port tgt", {28'h0, tq.target}, {28'h0, SAD_TGT_PORT});
      chk("port idx", {30'h0, tq.port_index}, 32'(p));
    end
  endtask

  // byte lanes and sizes, with one wait state at the target
  task automatic t_lanes();
    wcyc = 4'h1;
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, 1'b0, SAD_SIZE_BYTE, 32'h2000_0008 + 32'(k), 32'h11 * 32'(k + 1));
      chk("byte en", {28'h0, tq.byte_en}, 32'h1 << k);
    end
    xfer(1'b0, 1'b0, SAD_SIZE_WORD, 32'h2000_0008, 32'h0);
    chk("byte lanes", rd, 32'h4433_2211);
    xfer(1'b1, 1'b0, SAD_SIZE_HALF, 32'h2000_000E, 32'h0000_BEEF);
    chk("half en", {28'h0, tq.byte_en}, 32'hC);
    xfer(1'b0, 1'b0, SAD_SIZE_WORD, 32'h2000_000C, 32'h0);
    chk("half lanes", rd, 32'hBEEF_0000);
    a0 = acc;
    xfer(1'b1, 1'b0, SAD_SIZE_BAD, 32'h2000_000C, 32'h0);
    chk("bad size", {31'h0, flt}, 32'h1);
    xfer(1'b1, 1'b0, SAD_SIZE_WORD, 32'h2000_000E, 32'h0);
    chk("misaligned", {31'h0, flt}, 32'h1);
    chk("untouched", acc, a0);
  endtask

  // fetches from the peripheral range are refused
  task automatic t_exec_never();
    xfer(1'b0, 1'b1, SAD_SIZE_WORD, 32'h4000_4000, 32'h0);
    chk("exec never port", {31'h0, flt}, 32'h1);
    xfer(1'b0, 1'b1, SAD_SIZE_WORD, 32'h5FFF_FFFC, 32'h0);
    chk("exec never top", {31'h0, flt}, 32'h1);
    xfer(1'b0, 1'b1, SAD_SIZE_WORD, 32'h0000_0100, 32'h0);
    chk("fetch flash", {31'h0, flt}, 32'h0);
  endtask

  // bit alias writes and reads with a slow target
  task automatic t_alias();
    wcyc = 4'h2;
    xfer(1'b1, 1'b0, SAD_SIZE_WORD, 32'h2000_0004, 32'h0);
    a0 = acc;
    xfer(1'b1, 1'b0, SAD_SIZE_WORD, 32'h2200_0094, 32'h1);
    chk("rmw count", acc, a0 + 2);
    xfer(1'b0, 1'b0, SAD_SIZE_WORD, 32'h2000_0004, 32'h0);
    chk("sram bit", rd, 32'h20);
    xfer(1'b0, 1'b0, SAD_SIZE_WORD, 32'h2200_0094, 32'h0);
    chk("alias rd1", rd, 32'h1);
    xfer(1'b0, 1'b0, SAD_SIZE_WORD, 32'h2200_0090, 32'h0);
    chk("alias rd0", rd, 32'h0);
    xfer(1'b1, 1'b0, SAD_SIZE_WORD, 32'h2203_FFFC, 32'h1);
    xfer(1'b0, 1'b0, SAD_SIZE_WORD, 32'h2000_1FFC, 32'h0);
    chk("alias top", rd, 32'h8000_0000);
    xfer(1'b1, 1'b0, SAD_SIZE_WORD, 32'h4000_4000, 32'hF0);
    xfer(1'b1, 1'b0, SAD_SIZE_WORD, 32'h4208_000C, 32'h1);
    xfer(1'b0, 1'b0, SAD_SIZE_WORD, 32'h4000_4000, 32'h0);
    chk("periph bit", rd, 32'hF8);
    xfer(1'b0, 1'b0, SAD_SIZE_WORD, 32'h4208_0010, 32'h0);
    chk("periph rd", rd, 32'h1);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    i_rst = 1'b1;
    i_req = '0;
    wcyc = 4'h0;
    repeat (3) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    t_map();
    t_lanes();
    t_exec_never();
    t_alias();
    give_verdict();
  end

  // whole run is well under a thousand cycles
  initial begin
    #(5000 * 100);
    error_cnt++;
    give_verdict();
  end
endmodule
